// >>> rtl/kwu_key_wake_unit.v
// Key wake-up interrupt unit with AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "kwu_map.vh"

module kwu_key_wake_unit (
    input wire aclk,
    input wire aresetn,
    input wire por_n,
    input wire run_mode,
    input wire [3:0] port_a_low_pins,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg key_wake_irq
);

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    reg [3:0] pin_meta_q;
    reg [3:0] pin_sync_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
        end
        else
        begin
            pin_meta_q <= port_a_low_pins;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    reg key_wake_pending_flag_q;
    reg key_wake_irq_enable_q;
    reg key_detect_level_select_q;
    reg [3:0] key_pin_enable_q;
    reg [3:0] key_polarity_select_q;
    reg [1:0] evt_status_q;
    reg [1:0] evt_enable_q;

    // ----------------------------------------------------------------
    // Detection
    // ----------------------------------------------------------------
    reg [3:0] active_prev_q;
    wire [3:0] pin_active_level;
    wire [3:0] polarity_allowed;
    wire [3:0] pin_active;
    wire [3:0] pin_edge;
    wire edge_hit;
    wire level_hit;
    wire detect;

    // Rising/high sense only in run mode; low sense works always
    assign polarity_allowed = ~key_polarity_select_q | {4{run_mode}};
    assign pin_active_level = ~(pin_sync_q ^ key_polarity_select_q);
    assign pin_active = pin_active_level & key_pin_enable_q & polarity_allowed;
    // Previous value is gated too, so enabling a pin already active is an edge
    assign pin_edge = pin_active & ~active_prev_q;
    assign edge_hit = |pin_edge;
    assign level_hit = key_detect_level_select_q & (|pin_active);
    assign detect = edge_hit | level_hit;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_prev_q <= 4'h0;
        end
        else
        begin
            active_prev_q <= pin_active;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] aw_addr_q;
    reg [7:0] w_data_q;
    reg w_lane0_q;
    wire aw_hs;
    wire w_hs;
    wire do_write;
    wire wr_ok;
    wire wr_sc;
    wire wr_pe;
    wire wr_pol;
    wire wr_eclr;
    wire wr_een;
    wire ack_write;

    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign wr_sc = aw_addr_q == `KWU_ADDR_STATUS_CONTROL;
    assign wr_pe = aw_addr_q == `KWU_ADDR_PIN_ENABLE;
    assign wr_pol = aw_addr_q == `KWU_ADDR_POLARITY;
    assign wr_eclr = aw_addr_q == `KWU_ADDR_EVT_CLEAR;
    assign wr_een = aw_addr_q == `KWU_ADDR_EVT_ENABLE;
    assign wr_ok = wr_sc | wr_pe | wr_pol | wr_eclr | wr_een;
    // Only byte lane 0 carries register bits
    assign ack_write = do_write & w_lane0_q & wr_sc & w_data_q[`KWU_SC_ACK];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `KWU_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                s_axi_awready <= 1'b0;
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                s_axi_wready <= 1'b0;
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `KWU_RESP_OKAY : `KWU_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register updates
    // ----------------------------------------------------------------
    wire wr_lane;

    assign wr_lane = do_write & w_lane0_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            key_wake_irq_enable_q <= `KWU_RST_IRQ_EN;
            key_detect_level_select_q <= `KWU_RST_LEVEL_SEL;
            key_pin_enable_q <= `KWU_RST_PIN_ENABLE;
            key_polarity_select_q <= `KWU_RST_POLARITY;
            evt_enable_q <= `KWU_RST_EVT;
        end
        else
        begin
            if (wr_lane && wr_sc)
            begin
                key_wake_irq_enable_q <= w_data_q[`KWU_SC_IRQ_EN];
                key_detect_level_select_q <= w_data_q[`KWU_SC_LEVEL_SEL];
            end
            if (wr_lane && wr_pe)
            begin
                key_pin_enable_q <= w_data_q[3:0];
            end
            if (wr_lane && wr_pol)
            begin
                key_polarity_select_q <= w_data_q[3:0];
            end
            if (wr_lane && wr_een)
            begin
                evt_enable_q <= w_data_q[1:0];
            end
        end
    end

    // Of the two resets only power-on clears the flag; a detection beats an acknowledge
    always @(posedge aclk)
    begin
        if (!por_n)
        begin
            key_wake_pending_flag_q <= `KWU_RST_PENDING;
        end
        else if (detect)
        begin
            key_wake_pending_flag_q <= 1'b1;
        end
        else if (ack_write)
        begin
            key_wake_pending_flag_q <= 1'b0;
        end
        // Bus writes never load the flag itself
    end

    // ----------------------------------------------------------------
    // Interrupt event status
    // ----------------------------------------------------------------
    wire [1:0] evt_set;
    wire [1:0] evt_clr;

    assign evt_set = {ack_write & detect, detect};
    assign evt_clr = (wr_lane && wr_eclr) ? w_data_q[1:0] : 2'h0;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_status_q <= `KWU_RST_EVT;
            key_wake_irq <= 1'b0;
        end
        else
        begin
            // Set wins over clear so no event is lost
            evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
            key_wake_irq <= (key_wake_pending_flag_q & key_wake_irq_enable_q)
                | (|(evt_status_q & evt_enable_q));
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    wire ar_hs;
    reg [7:0] rd_byte;
    reg rd_ok;

    assign ar_hs = s_axi_arvalid & s_axi_arready;

    always @*
    begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `KWU_ADDR_STATUS_CONTROL:
            begin
                // Acknowledge reads zero, upper nibble zero
                rd_byte = {4'h0, key_wake_pending_flag_q, 1'b0,
                    key_wake_irq_enable_q, key_detect_level_select_q};
            end
            `KWU_ADDR_PIN_ENABLE:
            begin
                rd_byte = {4'h0, key_pin_enable_q};
            end
            `KWU_ADDR_POLARITY:
            begin
                rd_byte = {4'h0, key_polarity_select_q};
            end
            `KWU_ADDR_EVT_STATUS:
            begin
                rd_byte = {6'h00, evt_status_q};
            end
            `KWU_ADDR_EVT_CLEAR:
            begin
                rd_byte = 8'h00;
            end
            `KWU_ADDR_EVT_ENABLE:
            begin
                rd_byte = {6'h00, evt_enable_q};
            end
            default:
            begin
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `KWU_RESP_OKAY;
        end
        else
        begin
            if (ar_hs)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? `KWU_RESP_OKAY : `KWU_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// >>> rtl/kwu_map.vh
// Register map, field positions and reset values of the key wake-up unit
`ifndef KWU_MAP_VH
`define KWU_MAP_VH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define KWU_IDX_STATUS_CONTROL 8'h0C
`define KWU_IDX_PIN_ENABLE 8'h0D
`define KWU_IDX_POLARITY 8'h0E
`define KWU_IDX_EVT_STATUS 8'h10
`define KWU_IDX_EVT_CLEAR 8'h11
`define KWU_IDX_EVT_ENABLE 8'h12
`define KWU_ADDR_STATUS_CONTROL (`KWU_IDX_STATUS_CONTROL * 8'h04)
`define KWU_ADDR_PIN_ENABLE (`KWU_IDX_PIN_ENABLE * 8'h04)
`define KWU_ADDR_POLARITY (`KWU_IDX_POLARITY * 8'h04)
`define KWU_ADDR_EVT_STATUS (`KWU_IDX_EVT_STATUS * 8'h04)
`define KWU_ADDR_EVT_CLEAR (`KWU_IDX_EVT_CLEAR * 8'h04)
`define KWU_ADDR_EVT_ENABLE (`KWU_IDX_EVT_ENABLE * 8'h04)

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define KWU_SC_PENDING 3
`define KWU_SC_ACK 2
`define KWU_SC_IRQ_EN 1
`define KWU_SC_LEVEL_SEL 0
`define KWU_EVT_DETECT 0
`define KWU_EVT_ACK_WHILE_ACTIVE 1

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define KWU_RST_PENDING 1'h0
`define KWU_RST_IRQ_EN 1'h0
`define KWU_RST_LEVEL_SEL 1'h0
`define KWU_RST_PIN_ENABLE 4'h0
`define KWU_RST_POLARITY 4'h0
`define KWU_RST_EVT 2'h0
`define KWU_RESP_OKAY 2'h0
`define KWU_RESP_SLVERR 2'h2

`endif

// >>> tb/kwu_checker.sv
// Concurrent checks on the ports of the key wake-up unit
`timescale 1ns/1ps
`include "kwu_map.vh"
module kwu_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [7:0] ra_q;
    // ----------------------------------------------------------------
    // Address of the read in flight, needed to judge its data
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            ra_q <= s_axi_araddr;
    end
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_SC_RD: assert property (s_axi_rvalid && ra_q == `KWU_ADDR_STATUS_CONTROL
        |-> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[`KWU_SC_ACK])
        else $error("status/control read shows ack or upper bits");
    AST_RG_RD: assert property (s_axi_rvalid && (ra_q == `KWU_ADDR_PIN_ENABLE
        || ra_q == `KWU_ADDR_POLARITY) |-> s_axi_rdata[7:4] == 4'h0)
        else $error("pin register upper bits not zero");
    AST_UNMAP: assert property (s_axi_rvalid && ra_q == 8'h3C
        |-> s_axi_rresp == `KWU_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind kwu_key_wake_unit kwu_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> tb/kwu_pins.sv
// Far-side model driving the wake pins
`timescale 1ns/1ps
module kwu_pins (
    input wire aclk,
    input wire [3:0] lvl,
    output logic [3:0] port_a_low_pins
);
    // Pins are asynchronous; moving them off the edge exercises the synchroniser
    initial port_a_low_pins = 4'hF;
    always @(posedge aclk)
    begin
        port_a_low_pins <= #3 lvl;
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the key wake-up unit
`timescale 1ns/1ps
`include "kwu_map.vh"
module tb;
    logic aclk, aresetn, por_n, run_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [3:0] lvl, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, rv;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, key_wake_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] port_a_low_pins;
    int error_cnt, total_checks, seed, m_pe, m_ctl, m_pend;
    kwu_key_wake_unit dut (.*);
    kwu_pins far (.aclk, .lvl, .port_a_low_pins);
    initial
    begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Bus cycles: a lead-in edge keeps back-to-back calls from double driving
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'h0;
        chk("bvalid", s_axi_bvalid, 1);
        chk("bresp", s_axi_bresp, e);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= $random(seed);
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                s_axi_rready <= 1'h1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        rv = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rvalid", s_axi_rvalid & s_axi_rready, 1);
        chk("rresp", s_axi_rresp, e);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, `KWU_RESP_OKAY);
        chk($sformatf("rd %h", a), rv, e);
    endtask
    task sc(input logic [31:0] d);
        wr(`KWU_ADDR_STATUS_CONTROL, d, `KWU_RESP_OKAY);
        repeat (4) @(posedge aclk);
    endtask
    function automatic logic [31:0] m_sc();
        return {28'h0, m_pend[0], 1'h0, m_ctl[1:0]};
    endfunction
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {error_cnt, total_checks, m_pe, m_ctl, m_pend} = 0;
        seed = 32'h40C8;
        {aresetn, por_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, run_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {s_axi_awprot, s_axi_arprot} = 0;
        s_axi_wstrb = 4'hF;
        lvl = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        por_n <= 1'h1;
        rc(`KWU_ADDR_STATUS_CONTROL, 0);
        rc(`KWU_ADDR_PIN_ENABLE, 0);
        rc(`KWU_ADDR_POLARITY, 0);
        rd(8'h3C, `KWU_RESP_SLVERR);
        wr(8'h3C, 32'hFF, `KWU_RESP_SLVERR);
        // High pins with rising polarity stay quiet outside run mode
        repeat (4)
        begin
            m_pe = $random(seed);
            wr(`KWU_ADDR_PIN_ENABLE, m_pe, `KWU_RESP_OKAY);
            wr(`KWU_ADDR_POLARITY, ~m_pe, `KWU_RESP_OKAY);
            rc(`KWU_ADDR_PIN_ENABLE, m_pe & 15);
            rc(`KWU_ADDR_POLARITY, ~m_pe & 15);
        end
        wr(`KWU_ADDR_POLARITY, 32'h1, `KWU_RESP_OKAY);
        wr(`KWU_ADDR_PIN_ENABLE, 32'hF, `KWU_RESP_OKAY);
        sc(0);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        wr(`KWU_ADDR_PIN_ENABLE, 32'h0, `KWU_RESP_OKAY);
        run_mode <= 1'h1;
        sc(0);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        wr(`KWU_ADDR_PIN_ENABLE, 32'h1, `KWU_RESP_OKAY);
        m_pend = 1;
        sc(0);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        chk("irq", key_wake_irq, 0);
        m_ctl = 2;
        sc(2);
        chk("irq", key_wake_irq, 1);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        m_pend = 0;
        sc(32'hE);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        chk("irq", key_wake_irq, 0);
        m_ctl = 0;
        sc(8);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        // Level mode, with the event registers masking and raising the line
        wr(`KWU_ADDR_EVT_CLEAR, 32'h3, `KWU_RESP_OKAY);
        m_ctl = 1;
        m_pend = 1;
        sc(5);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        // No detection fell in the acknowledge cycle, so only the detection event is set
        rc(`KWU_ADDR_EVT_STATUS, 1);
        chk("irq", key_wake_irq, 0);
        wr(`KWU_ADDR_EVT_ENABLE, 32'h1, `KWU_RESP_OKAY);
        rc(`KWU_ADDR_EVT_ENABLE, 1);
        chk("irq", key_wake_irq, 1);
        lvl <= 4'h0;
        // Pin still seen active in the acknowledge cycle: detection wins
        sc(5);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        rc(`KWU_ADDR_EVT_STATUS, 3);
        m_pend = 0;
        sc(5);
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        wr(`KWU_ADDR_EVT_CLEAR, 32'h3, `KWU_RESP_OKAY);
        rc(`KWU_ADDR_EVT_STATUS, 0);
        rc(`KWU_ADDR_EVT_CLEAR, 0);
        chk("irq", key_wake_irq, 0);
        // Pending survives the bus reset; of the two resets only power-on clears it
        lvl <= 4'hF;
        m_pend = 1;
        sc(1);
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        m_ctl = 0;
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        rc(`KWU_ADDR_PIN_ENABLE, 0);
        chk("irq", key_wake_irq, 0);
        por_n <= 1'h0;
        repeat (3) @(posedge aclk);
        por_n <= 1'h1;
        m_pend = 0;
        rc(`KWU_ADDR_STATUS_CONTROL, m_sc());
        wrap_up();
    end
endmodule
